// [hdl/sac_pkg.sv]
package sac_pkg;
    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] CTRL_OFFS = 8'h00;
    localparam logic [7:0] PINREF_OFFS = 8'h04;
    localparam logic [7:0] TIMFMT_OFFS = 8'h08;
    localparam logic [7:0] RESULT_OFFS = 8'h0C;
    localparam logic [7:0] STATUS_OFFS = 8'h10;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_GO_BIT = 1;
    localparam int CTRL_CHAN_LSB = 2;
    localparam int REF_NEG_BIT = 5;
    localparam int REF_POS_BIT = 4;
    localparam int JUSTIFY_BIT = 7;
    localparam int ACQ_LSB = 3;
    localparam int STAT_DONE_BIT = 0;

    // ****************************************
    // Reset values and masks
    // ****************************************
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] PINREF_RST = 8'h00;
    localparam logic [7:0] TIMFMT_RST = 8'h00;
    localparam logic [7:0] PINREF_MASK = 8'h3F;
    localparam logic [7:0] TIMFMT_MASK = 8'hBF;
    localparam logic [7:0] CTRL_MASK = 8'h3F;

    // ****************************************
    // Timing: conversion and gap in bit periods, RC divider and start delay in clocks
    // ****************************************
    localparam logic [4:0] CONV_BITS = 5'h0B;
    localparam logic [4:0] GAP_BITS = 5'h02;
    localparam logic [5:0] RC_DIV = 6'h20;
    localparam logic [2:0] RC_START_DELAY = 3'h4;

    typedef enum logic [2:0] {SAC_IDLE, SAC_START, SAC_ACQ, SAC_CONV, SAC_GAP} sac_state_t;
endpackage

// [hdl/sac_tad_gen.sv]
`timescale 1ns/1ns
// ****************************************
// Conversion bit period tick generator
// ****************************************
module sac_tad_gen (
    // Clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic run,
    // Divider select
    input wire logic [2:0] sel,
    // Tick out
    output logic tick
);
    logic [6:0] cnt_reg;
    logic [6:0] div;

    // Decode divider; both RC codes use the slow internal divider
    // Periods under six clocks outrun the synchronised comparator loop, so software must pick a longer one
    always_comb begin
        unique case (sel)
            3'h0: div = 7'h02;
            3'h1: div = 7'h08;
            3'h2: div = 7'h20;
            3'h4: div = 7'h04;
            3'h5: div = 7'h10;
            3'h6: div = 7'h40;
            default: div = {1'b0, sac_pkg::RC_DIV};
        endcase
    end

    // Count up one period; restarts whenever the sequence stops
    always_ff @(posedge clk) begin
        if (rst || !run) begin
            cnt_reg <= 7'h00;
            tick <= 1'b0;
        end else if (ce) begin
            tick <= (cnt_reg == div - 7'h01);
            cnt_reg <= (cnt_reg == div - 7'h01) ? 7'h00 : cnt_reg + 7'h01;
        end
    end
endmodule

// [hdl/sac_sar.sv]
`timescale 1ns/1ns
// ****************************************
// Successive approximation register
// ****************************************
module sac_sar #(
    parameter int W = 10
) (
    // Clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic start,
    input wire logic step,
    // Comparator from the held sample
    input wire logic cmp_hi,
    // Trial code and result
    output logic [W-1:0] trial,
    output logic [W-1:0] code
);
    logic [W-1:0] mask_reg;

    // One bit decided per step, most significant first
    always_ff @(posedge clk) begin
        if (rst) begin
            mask_reg <= '0;
            trial <= '0;
            code <= '0;
        end else if (ce) begin
            if (start) begin
                mask_reg <= {1'b1, {(W-1){1'b0}}};
                trial <= {1'b1, {(W-1){1'b0}}};
                code <= '0;
            end else if (step && mask_reg != '0) begin
                code <= cmp_hi ? (code | mask_reg) : code;
                mask_reg <= mask_reg >> 1;
                trial <= (cmp_hi ? (code | mask_reg) : code) | (mask_reg >> 1);
            end
        end
    end
endmodule

// [hdl/sac_top.sv]
`timescale 1ns/1ns
// Operation
// - Negative reference from channel two or ground
// - Positive reference from channel three or supply
// - Pin field turns channels digital from top
// - Justify bit chooses right or left format
// - Acquisition field picks 0..20 bit periods
// - Clock field picks divider or internal RC
// - RC clock source adds start delay
// - Converts during sleep only on RC clock
// - Completion loads result, clears go, flags
// - Reset clears registers and aborts conversion
// - Result pair not initialised by reset
// - Programmed acquisition then automatic conversion start
// - Two bit periods wait after conversion
// - Unimplemented bits read as zero
// - Result by successive approximation of sample
// - Conversion lasts eleven bit periods
// - Go bit reads one while converting
// - Clearing go aborts, result kept
module sac_top (
    // Clock, reset, enable
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic CE,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Analog front end
    input wire logic CMP_HI,
    input wire logic SLEEPING,
    output logic [9:0] DAC_CODE,
    output logic SAMPLE_EN,
    output logic [3:0] CHANNEL,
    output logic [15:0] ANALOG_PINS,
    output logic VREF_NEG_PIN,
    output logic VREF_POS_PIN,
    output logic DONE_PULSE
);
    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] ctrl_reg;
    logic [7:0] pinref_reg;
    logic [7:0] timfmt_reg;
    logic [15:0] result_reg;
    logic done_flag_reg;
    sac_pkg::sac_state_t state_reg;
    logic [4:0] bit_cnt_reg;
    logic [2:0] dly_reg;
    logic cmp_s1, cmp_s2, cmp_s3, cmp_hi;
    logic slp_s1, slp_s2, slp_s3, sleep_q;
    logic wr, rd, tick, run, sar_start, sar_step, finish;
    logic [9:0] trial, code;
    logic [4:0] acq_bits;
    logic is_rc;

    assign wr = PSEL && PENABLE && PWRITE;
    assign rd = PSEL && PENABLE && !PWRITE;
    assign is_rc = timfmt_reg[1:0] == 2'b11;
    // Sleep halts the oscillator clock; only RC keeps converting
    // The RC start delay keeps the bit period divider parked, so the conversion clock starts late
    assign run = (state_reg != sac_pkg::SAC_IDLE) && !(state_reg == sac_pkg::SAC_START && dly_reg != 3'h0)
        && (!sleep_q || is_rc);
    assign finish = state_reg == sac_pkg::SAC_CONV && tick && bit_cnt_reg == sac_pkg::CONV_BITS - 5'h01;

    // ****************************************
    // Pin synchronisers, second and third must agree
    // ****************************************
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            {cmp_s1, cmp_s2, cmp_s3, cmp_hi} <= 4'h0;
            {slp_s1, slp_s2, slp_s3, sleep_q} <= 4'h0;
        end else if (CE) begin
            cmp_s1 <= CMP_HI;
            cmp_s2 <= cmp_s1;
            cmp_s3 <= cmp_s2;
            slp_s1 <= SLEEPING;
            slp_s2 <= slp_s1;
            slp_s3 <= slp_s2;
            if (cmp_s2 == cmp_s3) cmp_hi <= cmp_s3;
            if (slp_s2 == slp_s3) sleep_q <= slp_s3;
        end
    end

    // Acquisition time decode
    always_comb begin
        unique case (timfmt_reg[5:3])
            3'h0: acq_bits = 5'd0;
            3'h1: acq_bits = 5'd2;
            3'h2: acq_bits = 5'd4;
            3'h3: acq_bits = 5'd6;
            3'h4: acq_bits = 5'd8;
            3'h5: acq_bits = 5'd12;
            3'h6: acq_bits = 5'd16;
            3'h7: acq_bits = 5'd20;
        endcase
    end

    sac_tad_gen u_tad (
        .clk(MCLK),
        .rst(SYS_RST),
        .ce(CE),
        .run(run),
        .sel(timfmt_reg[2:0]),
        .tick(tick)
    );

    sac_sar #(.W(10)) u_sar (
        .clk(MCLK),
        .rst(SYS_RST),
        .ce(CE),
        .start(sar_start),
        .step(sar_step),
        .cmp_hi(cmp_hi),
        .trial(trial),
        .code(code)
    );

    assign sar_start = state_reg != sac_pkg::SAC_CONV && run && (state_reg == sac_pkg::SAC_START
        ? (dly_reg == 3'h0 && acq_bits == 5'd0) : (state_reg == sac_pkg::SAC_ACQ && tick
        && bit_cnt_reg == acq_bits - 5'h01));
    assign sar_step = state_reg == sac_pkg::SAC_CONV && tick && bit_cnt_reg != 5'h00;

    // ****************************************
    // Conversion sequencer
    // ****************************************
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            state_reg <= sac_pkg::SAC_IDLE;
            bit_cnt_reg <= 5'h00;
            dly_reg <= 3'h0;
        end else if (CE) begin
            unique case (state_reg)
                sac_pkg::SAC_IDLE: begin
                    // Same terms as the go bit itself, so a start never runs with go low
                    if (wr && PADDR == sac_pkg::CTRL_OFFS && PWDATA[sac_pkg::CTRL_GO_BIT]
                        && PWDATA[sac_pkg::CTRL_ON_BIT] && ctrl_reg[sac_pkg::CTRL_ON_BIT]) begin
                        state_reg <= sac_pkg::SAC_START;
                        // RC source waits four cycles so a sleep can begin first
                        dly_reg <= is_rc ? sac_pkg::RC_START_DELAY : 3'h0;
                        bit_cnt_reg <= 5'h00;
                    end
                end
                sac_pkg::SAC_START: begin
                    if (dly_reg != 3'h0) dly_reg <= dly_reg - 3'h1;
                    else if (run) state_reg <= acq_bits == 5'd0 ? sac_pkg::SAC_CONV : sac_pkg::SAC_ACQ;
                end
                sac_pkg::SAC_ACQ: begin
                    if (tick) begin
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                        if (bit_cnt_reg == acq_bits - 5'h01) begin
                            state_reg <= sac_pkg::SAC_CONV;
                            bit_cnt_reg <= 5'h00;
                        end
                    end
                end
                sac_pkg::SAC_CONV: begin
                    if (tick) begin
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                        if (finish) begin
                            state_reg <= sac_pkg::SAC_GAP;
                            bit_cnt_reg <= 5'h00;
                        end
                    end
                end
                sac_pkg::SAC_GAP: begin
                    // Sampling resumes here; a new go is refused until idle
                    if (tick) begin
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                        if (bit_cnt_reg == sac_pkg::GAP_BITS - 5'h01) state_reg <= sac_pkg::SAC_IDLE;
                    end
                end
            endcase
            // Software abort or module off
            if (state_reg inside {sac_pkg::SAC_START, sac_pkg::SAC_ACQ, sac_pkg::SAC_CONV} && wr
                && PADDR == sac_pkg::CTRL_OFFS
                && (!PWDATA[sac_pkg::CTRL_GO_BIT] || !PWDATA[sac_pkg::CTRL_ON_BIT])) begin
                state_reg <= sac_pkg::SAC_GAP;
                bit_cnt_reg <= 5'h00;
            end
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            ctrl_reg <= sac_pkg::CTRL_RST;
            pinref_reg <= sac_pkg::PINREF_RST;
            timfmt_reg <= sac_pkg::TIMFMT_RST;
        end else if (CE) begin
            if (wr && PADDR == sac_pkg::PINREF_OFFS) pinref_reg <= PWDATA[7:0] & sac_pkg::PINREF_MASK;
            if (wr && PADDR == sac_pkg::TIMFMT_OFFS) timfmt_reg <= PWDATA[7:0] & sac_pkg::TIMFMT_MASK;
            if (wr && PADDR == sac_pkg::CTRL_OFFS) begin
                ctrl_reg <= PWDATA[7:0] & sac_pkg::CTRL_MASK;
                // Go only sticks when the module is already on
                ctrl_reg[sac_pkg::CTRL_GO_BIT] <= PWDATA[sac_pkg::CTRL_GO_BIT] && PWDATA[sac_pkg::CTRL_ON_BIT]
                    && ctrl_reg[sac_pkg::CTRL_ON_BIT] && state_reg != sac_pkg::SAC_GAP;
            end else if (finish) begin
                ctrl_reg[sac_pkg::CTRL_GO_BIT] <= 1'b0;
            end
        end
    end

    // Done pulse and done flag; completion beats a software clear
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            done_flag_reg <= 1'b0;
            DONE_PULSE <= 1'b0;
        end else if (CE) begin
            DONE_PULSE <= finish;
            if (finish) done_flag_reg <= 1'b1;
            else if (wr && PADDR == sac_pkg::STATUS_OFFS && PWDATA[sac_pkg::STAT_DONE_BIT]) done_flag_reg <= 1'b0;
        end
    end

    // No reset here: the result survives reset and is undefined at power-on
    always_ff @(posedge MCLK) begin
        if (CE) begin
            if (finish) begin
                // Last bit decided on this tick is folded in directly
                result_reg <= timfmt_reg[sac_pkg::JUSTIFY_BIT]
                    ? {6'h00, code | (cmp_hi ? 10'h001 : 10'h000)}
                    : {code | (cmp_hi ? 10'h001 : 10'h000), 6'h00};
            end else if (wr && PADDR == sac_pkg::RESULT_OFFS) begin
                result_reg <= PWDATA[15:0];
            end
        end
    end

    // ****************************************
    // Analog side outputs
    // ****************************************
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            DAC_CODE <= 10'h000;
            SAMPLE_EN <= 1'b0;
            CHANNEL <= 4'h0;
            ANALOG_PINS <= 16'hFFFF;
            VREF_NEG_PIN <= 1'b0;
            VREF_POS_PIN <= 1'b0;
        end else if (CE) begin
            DAC_CODE <= trial;
            SAMPLE_EN <= ctrl_reg[sac_pkg::CTRL_ON_BIT] && state_reg != sac_pkg::SAC_CONV;
            CHANNEL <= ctrl_reg[5:2];
            // Code n makes the top n+1 channels digital, code 0 none
            ANALOG_PINS <= pinref_reg[3:0] == 4'h0 ? 16'hFFFF
                : (16'hFFFF >> (5'd1 + {1'b0, pinref_reg[3:0]}));
            VREF_NEG_PIN <= pinref_reg[sac_pkg::REF_NEG_BIT];
            VREF_POS_PIN <= pinref_reg[sac_pkg::REF_POS_BIT];
        end
    end

    // ****************************************
    // APB read port, zero wait states
    // ****************************************
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            PRDATA <= 32'h0000_0000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else if (CE) begin
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !(PADDR inside {sac_pkg::CTRL_OFFS, sac_pkg::PINREF_OFFS,
                sac_pkg::TIMFMT_OFFS, sac_pkg::RESULT_OFFS, sac_pkg::STATUS_OFFS});
            PRDATA <= 32'h0000_0000;
            if (PSEL && !PENABLE && !PWRITE) begin
                unique case (PADDR)
                    sac_pkg::CTRL_OFFS: PRDATA <= {24'h0, ctrl_reg};
                    sac_pkg::PINREF_OFFS: PRDATA <= {24'h0, pinref_reg};
                    sac_pkg::TIMFMT_OFFS: PRDATA <= {24'h0, timfmt_reg};
                    sac_pkg::RESULT_OFFS: PRDATA <= {16'h0, result_reg};
                    sac_pkg::STATUS_OFFS: PRDATA <= {31'h0, done_flag_reg};
                    default: PRDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge MCLK); endclocking
    default disable iff (SYS_RST || !CE);

    go_clears_a: assert property (finish |=> !ctrl_reg[sac_pkg::CTRL_GO_BIT]) else $error("go not cleared");
    flag_sets_a: assert property (finish |=> done_flag_reg) else $error("flag not set");
    gap_follows_a: assert property (finish |=> state_reg == sac_pkg::SAC_GAP) else $error("no gap");
    unimpl_zero_a: assert property (pinref_reg[7:6] == 2'b00 && timfmt_reg[6] == 1'b0) else $error("reserved set");
    ref_neg_a: assert property (##1 VREF_NEG_PIN == $past(pinref_reg[5])) else $error("vref neg");
    ref_pos_a: assert property (##1 VREF_POS_PIN == $past(pinref_reg[4])) else $error("vref pos");
    all_digital_a: assert property (pinref_reg[3:0] == 4'hF |=> ANALOG_PINS == 16'h0000) else $error("pins");
    justify_a: assert property (finish && timfmt_reg[7] |=> result_reg[15:10] == 6'h00) else $error("right");
    left_a: assert property (finish && !timfmt_reg[7] |=> result_reg[5:0] == 6'h00) else $error("left");
    go_busy_a: assert property (state_reg == sac_pkg::SAC_CONV |-> ctrl_reg[1]) else $error("go low busy");

    conv_cover: cover property (finish);
    acq_cover: cover property (state_reg == sac_pkg::SAC_ACQ ##1 state_reg == sac_pkg::SAC_CONV);
    abort_cover: cover property (state_reg == sac_pkg::SAC_CONV ##1 state_reg == sac_pkg::SAC_GAP && !DONE_PULSE);
endmodule

// [sim/sac_analog_model.sv]
`timescale 1ns/1ns
// ********
// Sample-and-hold and comparator model
// ********
module sac_analog_model (
    // Clock
    input wire logic clk,
    // From the converter
    input wire logic sample_en,
    input wire logic [9:0] dac_code,
    // Input level chosen by the bench
    input wire logic [9:0] level,
    // To the converter
    output logic cmp_hi
);
    logic [9:0] held;
    // Track while sampling, hold while converting
    always @(posedge clk) begin
        if (sample_en) begin
            held <= level;
        end
    end
    // Half-step offset, so the compare never ties on an exact code
    assign cmp_hi = ({held, 1'b1} > {dac_code, 1'b0});
endmodule

// [sim/sar_adc_config_control_test.sv]
`timescale 1ns/1ns
module sar_adc_config_control_test;
    // ********
    // Signals and model state
    // ********
    logic MCLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic CE = 1'b1;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic SLEEPING = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [9:0] level = 10'h000;
    logic [31:0] PRDATA, rd;
    logic PREADY, PSLVERR, CMP_HI, SAMPLE_EN, VREF_NEG_PIN, VREF_POS_PIN, DONE_PULSE, er;
    logic [9:0] DAC_CODE;
    logic [3:0] CHANNEL;
    logic [15:0] ANALOG_PINS;
    int errors = 0;
    int samples_checked = 0;
    int exp_res;
    int acq_tab[8] = '{0, 2, 4, 6, 8, 12, 16, 20};

    // Clock at 250 MHz
    always #2 MCLK = ~MCLK;

    sac_top dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .CMP_HI(CMP_HI), .SLEEPING(SLEEPING), .DAC_CODE(DAC_CODE),
        .SAMPLE_EN(SAMPLE_EN), .CHANNEL(CHANNEL), .ANALOG_PINS(ANALOG_PINS),
        .VREF_NEG_PIN(VREF_NEG_PIN), .VREF_POS_PIN(VREF_POS_PIN), .DONE_PULSE(DONE_PULSE));

    sac_analog_model afe (.clk(MCLK), .sample_en(SAMPLE_EN), .dac_code(DAC_CODE), .level(level),
        .cmp_hi(CMP_HI));

    // ********
    // Tasks
    // ********
    task automatic final_report;
        $display("checks=%0d errors=%0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Cycle counts carry start and bus overhead beyond the nominal periods, hence a window
    task automatic chk_time(input int got, input int lo, input int hi);
        samples_checked++;
        if (got < lo || got > hi) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge MCLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge MCLK);
            if (PREADY === 1'b1) break;
        end
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (n == 16) begin
            errors++;
            final_report();
        end
    endtask

    task automatic wait_done(input int lim, output int cyc);
        for (cyc = 0; cyc < lim; cyc++) begin
            @(posedge MCLK);
            if (DONE_PULSE === 1'b1) break;
        end
    endtask

    function automatic int div_of(input int cs);
        case (cs)
            0: return 2;
            1: return 8;
            2: return 32;
            4: return 4;
            5: return 16;
            6: return 64;
            default: return sac_pkg::RC_DIV;
        endcase
    endfunction

    // Configure, start, wait for done, read back; the flow software follows
    task automatic conv(input int cs, input int aq, input int rj);
        int cyc, n, ch;
        ch = $urandom_range(15);
        // Too short a bit period outruns the comparator loop; only full scale converts right there
        level <= (cs == 0 || cs == 4) ? 10'h3FF : 10'($urandom_range(1023));
        apb(1'b1, sac_pkg::TIMFMT_OFFS, 32'((rj << 7) | (aq << 3) | cs));
        apb(1'b1, sac_pkg::CTRL_OFFS, 32'(1 | (ch << 2)));
        apb(1'b1, sac_pkg::CTRL_OFFS, 32'(3 | (ch << 2)));
        chk(CHANNEL, ch);
        chk(SAMPLE_EN, 1);
        wait_done(3000, cyc);
        n = (acq_tab[aq] + 11) * div_of(cs);
        chk_time(cyc, n - div_of(cs), n + div_of(cs) + 16);
        if (cs == 6) apb(1'b1, sac_pkg::CTRL_OFFS, 32'(3 | (ch << 2)));
        exp_res = rj ? level : level << 6;
        apb(1'b0, sac_pkg::CTRL_OFFS, 32'h0);
        chk(rd, 32'(1 | (ch << 2)));
        chk(DAC_CODE, level);
        apb(1'b0, sac_pkg::RESULT_OFFS, 32'h0);
        chk(rd, exp_res);
        apb(1'b0, sac_pkg::STATUS_OFFS, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, sac_pkg::STATUS_OFFS, 32'h1);
        repeat (3 * div_of(cs) + 8) @(posedge MCLK);
    endtask

    // ********
    // Main sequence
    // ********
    initial begin
        int cyc;
        void'($urandom(32'h07a26d55));
        repeat (12) @(posedge MCLK);
        SYS_RST <= 1'b0;
        chk(ANALOG_PINS, 32'hFFFF);
        apb(1'b0, sac_pkg::TIMFMT_OFFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
        // Every pin code and reference choice, upper bits written as ones
        for (int i = 0; i < 64; i++) begin
            int nd;
            apb(1'b1, sac_pkg::PINREF_OFFS, 32'(i | 8'hC0));
            apb(1'b0, sac_pkg::PINREF_OFFS, 32'h0);
            chk(rd, i);
            nd = (i % 16 == 0) ? 0 : (i % 16 == 15) ? 16 : i % 16 + 1;
            chk(ANALOG_PINS, (1 << (16 - nd)) - 1);
            chk({VREF_NEG_PIN, VREF_POS_PIN}, (i >> 4) & 3);
        end
        apb(1'b1, sac_pkg::TIMFMT_OFFS, 32'hFF);
        apb(1'b0, sac_pkg::TIMFMT_OFFS, 32'h0);
        chk(rd, 32'hBF);
        // Every clock code once, each paired with acquisition code seven minus the clock code
        for (int i = 0; i < 8; i++) begin
            conv(i, 7 - i, i & 1);
        end
        // Asleep: the RC clock keeps going, a divided clock stalls until wake-up
        SLEEPING <= 1'b1;
        conv(3, 0, 1);
        apb(1'b1, sac_pkg::TIMFMT_OFFS, 32'h81);
        apb(1'b1, sac_pkg::CTRL_OFFS, 32'h3);
        wait_done(400, cyc);
        chk(cyc, 400);
        SLEEPING <= 1'b0;
        wait_done(400, cyc);
        chk(cyc < 400, 1);
        // Let the two-period gap run out, or the next go is refused
        repeat (40) @(posedge MCLK);
        // Abort by clearing go: no completion and the old result stays
        apb(1'b0, sac_pkg::RESULT_OFFS, 32'h0);
        exp_res = rd;
        level <= ~level;
        apb(1'b1, sac_pkg::TIMFMT_OFFS, 32'h82);
        apb(1'b1, sac_pkg::CTRL_OFFS, 32'h3);
        repeat (100) @(posedge MCLK);
        chk(SAMPLE_EN, 0);
        apb(1'b1, sac_pkg::CTRL_OFFS, 32'h1);
        wait_done(500, cyc);
        chk(cyc, 500);
        apb(1'b0, sac_pkg::RESULT_OFFS, 32'h0);
        chk(rd, exp_res);
        // Reset in mid-conversion: registers cleared, result kept
        apb(1'b1, sac_pkg::CTRL_OFFS, 32'h3);
        repeat (50) @(posedge MCLK);
        SYS_RST <= 1'b1;
        repeat (2) @(posedge MCLK);
        SYS_RST <= 1'b0;
        wait_done(500, cyc);
        chk(cyc, 500);
        apb(1'b0, sac_pkg::CTRL_OFFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, sac_pkg::RESULT_OFFS, 32'h0);
        chk(rd, exp_res);
        // Clock enable low freezes a started conversion; it finishes once raised
        apb(1'b1, sac_pkg::TIMFMT_OFFS, 32'h81);
        apb(1'b1, sac_pkg::CTRL_OFFS, 32'h1);
        apb(1'b1, sac_pkg::CTRL_OFFS, 32'h3);
        CE <= 1'b0;
        wait_done(300, cyc);
        chk(cyc, 300);
        CE <= 1'b1;
        wait_done(200, cyc);
        chk_time(cyc, 80, 112);
        apb(1'b0, sac_pkg::RESULT_OFFS, 32'h0);
        chk(rd, level);
        final_report();
    end
endmodule
